// >>> rtl/s2mdc_pkg.sv
// Shared constants and carriers for the stream-to-memory DMA control block.
package s2mdc_pkg;
   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [11:0] ADDR_COMMON_CONTROL = 12'h500;
   localparam logic [11:0] ADDR_COMMON_STATUS  = 12'h504;
   localparam logic [11:0] ADDR_CHANNEL_ENABLE = 12'h508;
   localparam logic [11:0] ADDR_CHANNEL_IN_PROG = 12'h50c;
   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int          CTRL_RUN_STOP_POS   = 0;
   localparam int          CTRL_SOFT_RESET_POS = 2;
   localparam int          STAT_HALTED_POS     = 0;
   localparam int          STAT_IDLE_POS       = 1;
   localparam int          NUM_CHANNELS        = 16;
   localparam logic [15:0] CHAN_ENABLE_RESET   = 16'h0001;
   localparam logic [15:0] CHAN_IN_PROG_RESET  = 16'h0000;
   localparam logic [31:0] UNMAPPED_READ       = 32'h0000_0000;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int          SYNC_STAGES         = 3;
   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic        valid;
      logic        last;
      logic [3:0]  dest;
   } s2mdc_beat_t;
   typedef struct packed {
      logic        idle;
      logic        halted;
   } s2mdc_status_t;
endpackage

// >>> rtl/s2mdc_sync.sv
// Three-stage synchroniser for a level from outside the clock domain.
`timescale 1ns/100ps
module s2mdc_sync (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_async,
   output logic      o_level
);
   logic [2:0] stage_reg;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         stage_reg <= 3'h0;
         o_level   <= 1'b0;
      end else begin
         stage_reg <= {stage_reg[1:0], i_async};
         if (stage_reg[2] == stage_reg[1]) begin
            o_level <= stage_reg[2];
         end
      end
   end
endmodule

// >>> rtl/s2mdc_ctrl.sv
// Common control and status registers with packet gating for the stream-to-memory path.
//
// Notes on behaviour
// - Writing soft reset 1 starts a graceful engine reset, flushing pending transfers.
// - Soft reset bit reads 1 while in progress; afterwards all registers default.
// - A stream-to-memory soft reset also resets the memory-to-stream path.
// - Clearing run/stop stops the engine only after current operations end.
// - Queued descriptor status updates finish writing back before halting.
// - Halted flag becomes 1 only once the engine has fully halted; here it reads 1 from the start of a soft reset, before the flush ends.
// - Hardware clears run/stop by itself when an error is detected.
// - Stopped engine discards every packet arriving on its stream input.
// - Setting run/stop starts operations; halted drops to 0 when operating.
// - After reset status shows halted 1 and idle 0.
// - Idle is 1 only when all channels reached tail and descriptors done.
// - A tail pointer write restarts operations from idle.
// - Channel enable bits 15:0, one per destination, reset value 0x1.
// - A packet for a disabled channel is discarded whole.
// - Disabling a channel does not stop its descriptor fetching.
// - New enable value applies when the stream is empty or next packet starts.
// - Disabling a channel leaves its interrupt behaviour unchanged.
// - Channel in progress shows the serviced channel, holding the last when idle.
// - Channel in progress is one-hot, reset 0x0, bit n for destination n.
`timescale 1ns/100ps
module s2mdc_ctrl #(
   parameter int NUM_CH = s2mdc_pkg::NUM_CHANNELS
) (
   input  wire logic                   i_clk,
   input  wire logic                   i_rst_n,
   input  wire logic [11:0]            i_addr,
   input  wire logic [31:0]            i_wdata,
   input  wire logic                   i_wr,
   input  wire logic                   i_rd,
   output logic      [31:0]            o_rdata,
   input  wire s2mdc_pkg::s2mdc_beat_t i_beat,
   output logic                        o_beat_accept,
   output logic                        o_beat_drop,
   input  wire logic                   i_engine_busy,
   input  wire logic                   i_update_pending,
   input  wire logic [NUM_CH-1:0]      i_at_tail,
   input  wire logic                   i_tail_write,
   input  wire logic                   i_error,
   input  wire logic                   i_flush_done,
   output logic                        o_run,
   output logic                        o_fetch_enable,
   output logic                        o_engine_reset,
   output logic                        o_memory_to_stream_path_reset,
   output logic [NUM_CH-1:0]           o_chan_enable,
   output logic                        o_halted
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      S2MDC_HALTED   = 2'b00,
      S2MDC_RUNNING  = 2'b01,
      S2MDC_STOPPING = 2'b11,
      S2MDC_RESETTING = 2'b10
   } s2mdc_state_t;

   s2mdc_state_t        state_reg;
   s2mdc_state_t        state_next;
   logic                run_stop_reg;
   logic                idle_reg;
   logic [NUM_CH-1:0]   enable_reg;
   logic [NUM_CH-1:0]   enable_live_reg;
   logic [NUM_CH-1:0]   in_prog_reg;
   logic                in_packet_reg;
   logic                pkt_pass_reg;
   logic                flush_level;
   logic                wr_ctrl;
   logic                wr_enable;
   logic                all_tail;
   logic                beat_ok;
   logic                soft_rst;

   assign wr_ctrl   = i_wr && (i_addr == s2mdc_pkg::ADDR_COMMON_CONTROL);
   assign wr_enable = i_wr && (i_addr == s2mdc_pkg::ADDR_CHANNEL_ENABLE);
   assign all_tail  = &i_at_tail;
   assign soft_rst  = (state_reg == S2MDC_RESETTING) && flush_level;

   // ---------------------------------------------------------------
   // Flush completion crossing
   // ---------------------------------------------------------------
   s2mdc_sync u_flush_sync (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_async (i_flush_done),
      .o_level (flush_level)
   );

   // ---------------------------------------------------------------
   // Engine state machine
   // ---------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         S2MDC_HALTED: begin
            if (run_stop_reg) begin
               state_next = S2MDC_RUNNING;
            end
         end
         S2MDC_RUNNING: begin
            if (!run_stop_reg) begin
               state_next = S2MDC_STOPPING;
            end
         end
         S2MDC_STOPPING: begin
            if (run_stop_reg) begin
               state_next = S2MDC_RUNNING;
            end else if (!i_engine_busy && !i_update_pending) begin
               state_next = S2MDC_HALTED;
            end
         end
         S2MDC_RESETTING: begin
            state_next = S2MDC_RESETTING;
         end
      endcase
      if (wr_ctrl && i_wdata[s2mdc_pkg::CTRL_SOFT_RESET_POS]) begin
         state_next = S2MDC_RESETTING;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n || soft_rst) begin
         state_reg <= S2MDC_HALTED;
      end else begin
         state_reg <= state_next;
      end
   end

   // ---------------------------------------------------------------
   // Run/stop control
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rst_n || soft_rst) begin
         run_stop_reg <= 1'b0;
      end else if (state_reg == S2MDC_RESETTING) begin
         run_stop_reg <= 1'b0;
      end else if (i_error) begin
         run_stop_reg <= 1'b0;
      end else if (wr_ctrl) begin
         run_stop_reg <= i_wdata[s2mdc_pkg::CTRL_RUN_STOP_POS];
      end
   end

   // ---------------------------------------------------------------
   // Idle tracking
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rst_n || soft_rst) begin
         idle_reg <= 1'b0;
      end else if (i_tail_write) begin
         idle_reg <= 1'b0;
      end else begin
         idle_reg <= (state_reg == S2MDC_RUNNING) && all_tail
                     && !i_engine_busy && !i_update_pending;
      end
   end

   // ---------------------------------------------------------------
   // Channel enable register and its live copy
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rst_n || soft_rst) begin
         enable_reg <= s2mdc_pkg::CHAN_ENABLE_RESET[NUM_CH-1:0];
      end else if (wr_enable) begin
         enable_reg <= i_wdata[NUM_CH-1:0];
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n || soft_rst) begin
         enable_live_reg <= s2mdc_pkg::CHAN_ENABLE_RESET[NUM_CH-1:0];
      end else if (!in_packet_reg) begin
         enable_live_reg <= enable_reg;
      end
   end

   // ---------------------------------------------------------------
   // Packet gating
   // ---------------------------------------------------------------
   assign beat_ok = (state_reg == S2MDC_RUNNING)
                    && enable_live_reg[i_beat.dest];

   always_ff @(posedge i_clk) begin
      if (!i_rst_n || soft_rst) begin
         in_packet_reg <= 1'b0;
         pkt_pass_reg  <= 1'b0;
      end else if (i_beat.valid) begin
         in_packet_reg <= !i_beat.last;
         if (!in_packet_reg) begin
            pkt_pass_reg <= beat_ok;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n || soft_rst) begin
         o_beat_accept <= 1'b0;
         o_beat_drop   <= 1'b0;
      end else begin
         o_beat_accept <= i_beat.valid && (in_packet_reg ? pkt_pass_reg : beat_ok);
         o_beat_drop   <= i_beat.valid && !(in_packet_reg ? pkt_pass_reg : beat_ok);
      end
   end

   // ---------------------------------------------------------------
   // Channel in progress
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rst_n || soft_rst) begin
         in_prog_reg <= s2mdc_pkg::CHAN_IN_PROG_RESET[NUM_CH-1:0];
      end else if (i_beat.valid && !in_packet_reg && beat_ok) begin
         in_prog_reg <= NUM_CH'(1) << i_beat.dest;
      end
   end

   // ---------------------------------------------------------------
   // Engine-facing outputs
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_run          <= 1'b0;
         o_fetch_enable <= 1'b0;
         o_engine_reset <= 1'b0;
         o_memory_to_stream_path_reset   <= 1'b0;
         o_chan_enable  <= s2mdc_pkg::CHAN_ENABLE_RESET[NUM_CH-1:0];
         o_halted       <= 1'b1;
      end else begin
         o_run          <= (state_next == S2MDC_RUNNING);
         o_fetch_enable <= (state_next == S2MDC_RUNNING);
         o_engine_reset <= (state_next == S2MDC_RESETTING) && !soft_rst;
         o_memory_to_stream_path_reset   <= (state_next == S2MDC_RESETTING) && !soft_rst;
         o_chan_enable  <= soft_rst ? s2mdc_pkg::CHAN_ENABLE_RESET[NUM_CH-1:0]
                                    : enable_live_reg;
         o_halted       <= soft_rst || (state_next == S2MDC_HALTED)
                           || (state_next == S2MDC_RESETTING);
      end
   end

   // ---------------------------------------------------------------
   // Register read port
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_rdata <= s2mdc_pkg::UNMAPPED_READ;
      end else if (i_rd) begin
         o_rdata <= s2mdc_pkg::UNMAPPED_READ;
         unique case (i_addr)
            s2mdc_pkg::ADDR_COMMON_CONTROL: begin
               o_rdata[s2mdc_pkg::CTRL_RUN_STOP_POS]   <= run_stop_reg;
               o_rdata[s2mdc_pkg::CTRL_SOFT_RESET_POS] <=
                  (state_reg == S2MDC_RESETTING);
            end
            s2mdc_pkg::ADDR_COMMON_STATUS: begin
               o_rdata[s2mdc_pkg::STAT_HALTED_POS] <= (state_reg == S2MDC_HALTED)
                  || (state_reg == S2MDC_RESETTING);
               o_rdata[s2mdc_pkg::STAT_IDLE_POS]   <= idle_reg;
            end
            s2mdc_pkg::ADDR_CHANNEL_ENABLE: begin
               o_rdata[NUM_CH-1:0] <= enable_reg;
            end
            s2mdc_pkg::ADDR_CHANNEL_IN_PROG: begin
               o_rdata[NUM_CH-1:0] <= in_prog_reg;
            end
            default: begin
               o_rdata <= s2mdc_pkg::UNMAPPED_READ;
            end
         endcase
      end else begin
         o_rdata <= s2mdc_pkg::UNMAPPED_READ;
      end
   end
endmodule

// >>> test/s2mdc_assertions.sv
// Concurrent checks on the ports of the stream-to-memory DMA control block.
`timescale 1ns/100ps
module s2mdc_assertions #(
   parameter int NUM_CH = 16
) (
   input wire logic                   i_clk,
   input wire logic                   i_rst_n,
   input wire logic [11:0]            i_addr,
   input wire logic [31:0]            i_wdata,
   input wire logic                   i_wr,
   input wire s2mdc_pkg::s2mdc_beat_t i_beat,
   input wire logic                   o_beat_accept,
   input wire logic                   o_beat_drop,
   input wire logic                   i_engine_busy,
   input wire logic                   i_update_pending,
   input wire logic                   i_error,
   input wire logic                   o_run,
   input wire logic                   o_fetch_enable,
   input wire logic                   o_engine_reset,
   input wire logic                   o_memory_to_stream_path_reset,
   input wire logic [NUM_CH-1:0]      o_chan_enable,
   input wire logic                   o_halted
);
   // ---------------------------------------------------------------
   // Packet boundary tracking and checks
   // ---------------------------------------------------------------
   logic first_reg;
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) first_reg <= 1'b1;
      else if (i_beat.valid) first_reg <= i_beat.last;
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   property p_rst; $rose(i_rst_n) |-> o_halted && o_chan_enable == 1 && !o_run; endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
   property p_one; i_beat.valid |=> o_beat_accept ^ o_beat_drop; endproperty
   a_one: assert property (p_one) else $error("beat not answered once");
   property p_stop; o_halted && i_beat.valid |=> o_beat_drop; endproperty
   a_stop: assert property (p_stop) else $error("beat kept while stopped");
   property p_dis; first_reg && i_beat.valid && !o_chan_enable[i_beat.dest] |=> o_beat_drop; endproperty
   a_dis: assert property (p_dis) else $error("disabled channel kept");
   property p_whole;
      !first_reg && i_beat.valid && $past(i_beat.valid) |=> o_beat_accept == $past(o_beat_accept);
   endproperty
   a_whole: assert property (p_whole) else $error("packet split");
   property p_live; !first_reg && !(i_beat.valid && i_beat.last) |=> $stable(o_chan_enable); endproperty
   a_live: assert property (p_live) else $error("enable changed in packet");
   property p_run;
      i_wr && i_addr == 12'h500 && i_wdata[0] && !i_wdata[2] && !i_error |-> ##2 o_run && !o_halted;
   endproperty
   a_run: assert property (p_run) else $error("run not started");
   property p_halt; $rose(o_halted) |-> !$past(i_engine_busy) && !$past(i_update_pending); endproperty
   a_halt: assert property (p_halt) else $error("halted too early");
   property p_soft; i_wr && i_addr == 12'h500 && i_wdata[2] |=> o_engine_reset && o_memory_to_stream_path_reset; endproperty
   a_soft: assert property (p_soft) else $error("soft reset not issued");
   property p_fetch; o_fetch_enable == o_run; endproperty
   a_fetch: assert property (p_fetch) else $error("fetch gated by channel");
endmodule
bind s2mdc_ctrl s2mdc_assertions #(.NUM_CH(NUM_CH)) u_chk (.i_clk, .i_rst_n, .i_addr, .i_wdata,
   .i_wr, .i_beat, .o_beat_accept, .o_beat_drop, .i_engine_busy, .i_update_pending, .i_error,
   .o_run, .o_fetch_enable, .o_engine_reset, .o_memory_to_stream_path_reset, .o_chan_enable, .o_halted);

// >>> test/s2mdc_source.sv
// Stream source that feeds whole packets of contiguous beats into the block.
`timescale 1ns/100ps
module s2mdc_source (
   input  wire logic              i_clk,
   output s2mdc_pkg::s2mdc_beat_t o_beat
);
   initial o_beat = '0;
   // Idle lines show the inverse of the last value so stale data is never reused.
   task send(input logic [3:0] d, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge i_clk);
         o_beat <= '{valid: 1'b1, last: (i == n - 1), dest: d};
      end
      @(posedge i_clk);
      o_beat <= '{valid: 1'b0, last: !o_beat.last, dest: ~o_beat.dest};
   endtask
endmodule

// >>> test/stream_to_memory_dma_control_bench.sv
// Self-checking bench for the stream-to-memory DMA control block.
`timescale 1ns/100ps
`define CHK(got, exp, msg) begin tests_run++; if ((got) !== (exp)) begin mismatches++; \
   $display("CHECK FAILED at %0t: %s", $time, msg); end end
module stream_to_memory_dma_control_bench;
   logic                   clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, busy = 1'b0;
   logic                   pend = 1'b0, tail_wr = 1'b0, err = 1'b0, flush = 1'b0;
   logic [11:0]            addr = 12'h000;
   logic [31:0]            wdata = 32'h0, rdata, r;
   logic [15:0]            at_tail = 16'hffff, en_m = 16'h0001, ip_m = 16'h0000;
   logic                   acc, drp, run_m = 1'b0, first = 1'b1, dec;
   s2mdc_pkg::s2mdc_beat_t beat;
   bit                     q[$];
   int                     mismatches = 0, tests_run = 0, cyc = 0, seed = 17, n;
   s2mdc_source u_src (.i_clk(clk), .o_beat(beat));
   s2mdc_ctrl dut (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
      .i_rd(rd), .o_rdata(rdata), .i_beat(beat), .o_beat_accept(acc), .o_beat_drop(drp),
      .i_engine_busy(busy), .i_update_pending(pend), .i_at_tail(at_tail),
      .i_tail_write(tail_wr), .i_error(err), .i_flush_done(flush), .o_run(),
      .o_fetch_enable(), .o_engine_reset(), .o_memory_to_stream_path_reset(), .o_chan_enable(), .o_halted());
   always #25 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         complete_run;
      end
   end
   // Model of the packet decision, taken at the first beat of each packet.
   always @(posedge clk) begin
      if (acc || drp) `CHK(acc, q.pop_front(), "beat decision")
      if (beat.valid) begin
         if (first) dec = run_m && en_m[beat.dest];
         if (first && dec) ip_m = 16'h1 << beat.dest;
         q.push_back(dec);
         first = beat.last;
      end
   end
   task complete_run;
      $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task wr32(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      if (a == 12'h508) en_m = d[15:0];
      if (a == 12'h500) run_m = d[0];
   endtask
   task rd32(input logic [11:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 `CHK(rdata, e, "register read")
   endtask
   task pkt(input logic [3:0] d);
      n = 1 + $unsigned($random(seed)) % 3;
      u_src.send(d, n);
      repeat (2) @(posedge clk);
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      rd32(12'h504, 32'h1);
      rd32(12'h508, 32'h1);
      rd32(12'h50c, 32'h0);
      wr32(12'h504, 32'hffff_ffff);
      wr32(12'h600, 32'hffff_ffff);
      rd32(12'h504, 32'h1);
      rd32(12'h600, 32'h0);
      rd32(12'h500, 32'h0);
      pkt(4'h0);
      wr32(12'h500, 32'h1);
      repeat (2) @(posedge clk);
      rd32(12'h504, 32'h2);
      @(posedge clk) at_tail[3] <= 1'b0;
      rd32(12'h504, 32'h0);
      @(posedge clk) at_tail[3] <= 1'b1;
      @(posedge clk) tail_wr <= 1'b1;
      @(posedge clk) tail_wr <= 1'b0;
      repeat (3) @(posedge clk);
      rd32(12'h504, 32'h2);
      r = $random(seed);
      wr32(12'h508, r | 32'h1);
      rd32(12'h508, {16'h0, r[15:0] | 16'h1});
      for (int i = 0; i < 16; i++) begin
         pkt(i[3:0]);
         rd32(12'h50c, {16'h0, ip_m});
      end
      wr32(12'h508, 32'h2);
      fork
         u_src.send(4'h1, 4);
         begin
            repeat (2) @(posedge clk);
            wr32(12'h508, 32'h0);
         end
      join
      pkt(4'h1);
      @(posedge clk) busy <= 1'b1;
      wr32(12'h500, 32'h0);
      repeat (4) @(posedge clk);
      rd32(12'h504, 32'h0);
      @(posedge clk) busy <= 1'b0;
      pend <= 1'b1;
      repeat (4) @(posedge clk);
      rd32(12'h504, 32'h0);
      @(posedge clk) pend <= 1'b0;
      repeat (3) @(posedge clk);
      rd32(12'h504, 32'h1);
      wr32(12'h500, 32'h1);
      @(posedge clk) err <= 1'b1;
      @(posedge clk) err <= 1'b0;
      rd32(12'h500, 32'h0);
      repeat (3) @(posedge clk);
      rd32(12'h504, 32'h1);
      wr32(12'h508, 32'hff);
      wr32(12'h500, 32'h4);
      rd32(12'h500, 32'h4);
      @(posedge clk) flush <= 1'b1;
      repeat (8) @(posedge clk);
      flush <= 1'b0;
      repeat (4) @(posedge clk);
      en_m = 16'h0001;
      run_m = 1'b0;
      rd32(12'h500, 32'h0);
      rd32(12'h508, 32'h1);
      rd32(12'h504, 32'h1);
      wr32(12'h500, 32'h1);
      pkt(4'h0);
      rd32(12'h50c, 32'h1);
      complete_run;
   end
endmodule
